// >>> line_proto_pkg.sv
// shared constants and types for the remote ascii line handler
// assumes a byte-wide receive stream and byte-wide transmit stream outside
package line_proto_pkg;
    localparam logic [7:0] CH_NL = 8'h0A;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_ACK = 8'h06;
    localparam logic [7:0] CH_BEL = 8'h07;
    localparam logic [7:0] CH_EOT = 8'h04;
    localparam logic [7:0] CH_ENQ = 8'h05;
    localparam logic [7:0] CH_GS = 8'h1D;
    localparam logic [7:0] CH_BS = 8'h08;
    localparam logic [7:0] CH_DEL = 8'h7F;
    localparam logic [7:0] CH_DEL2 = 8'hC3;
    localparam logic [7:0] CH_ECHO_OFF = 8'h12;
    localparam logic [7:0] CH_ECHO_ON = 8'h14;
    localparam logic [7:0] CH_EOT_ON = 8'h0E;
    localparam logic [7:0] CH_EOT_OFF = 8'h0F;
    localparam logic [15:0] TCP_PORT = 16'h1771;
    // register byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_IRQ = 8'h08;
    localparam logic [7:0] A_MASK = 8'h0C;
    localparam logic [7:0] A_LINE = 8'h10;
    localparam logic [7:0] A_RESULT = 8'h14;
    localparam logic [7:0] A_SERCFG = 8'h18;
    localparam logic [7:0] A_PORT = 8'h1C;
    localparam logic [7:0] A_BUF = 8'h40;
    // ctrl bits
    localparam int C_ECHO = 0;
    localparam int C_EOT = 1;
    localparam int C_CASE = 2;
    // irq bits
    localparam int I_LINE = 0;
    localparam int I_OVF = 1;
    localparam int I_DONE = 2;
    localparam logic [31:0] SERCFG_RST = 32'h0000_2580;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_t;
endpackage

// >>> remote_line.sv
// remote ascii line handler: assembles, echoes, frames replies
// assumes an rx byte stream from a uart or tcp front end and a tx sink with ready;
// software reads completed lines and posts the verdict over axi4-lite
`timescale 1ns/1ps
module remote_line
    import line_proto_pkg::*;
#(
    parameter int DEPTH = 64
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // character streams
    input wire byte_t rx,
    output byte_t tx,
    input wire logic tx_ready,
    // status
    output logic [31:0] ser_cfg,
    output logic [15:0] listen_port,
    output logic irq
);
    localparam int AW = $clog2(DEPTH);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_TERM = 3'b001,
        S_WAIT = 3'b010,
        S_TEXT = 3'b011,
        S_CR = 3'b100,
        S_NL = 3'b101,
        S_CODE = 3'b110,
        S_EOT = 3'b111
    } st_t;
    function automatic logic [7:0] upcase(input logic [7:0] c);
        upcase = (c >= 8'h61 && c <= 8'h7A) ? (c - 8'h20) : c;
    endfunction
    // canned text: ERROR: and REMOTE
    function automatic logic [7:0] text_char(input logic rem, input logic [2:0] i);
        logic [47:0] s;
        s = rem ? 48'h52454D4F5445 : 48'h4552524F523A;
        text_char = s[8'(47 - 8 * i) -: 8];
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0] buf_q [DEPTH];
    logic [AW:0] len_q, len_d;
    logic echo_q, echo_d, eot_q, eot_d, rem_q, rem_d, ok_q, ok_d, ovf_q, ovf_d;
    st_t st_q, st_d;
    logic [2:0] idx_q, idx_d, irq_q, irq_d, mask_q, mask_d, ev;
    logic [7:0] term_q, term_d, awa_q, awa_d;
    byte_t tx_q, tx_d;
    logic [31:0] ser_q, ser_d, wd_q, wd_d, rd_q, rd_d;
    logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    // ready flags kept in their own flops so bus outputs carry no gate
    logic awrdy_q, wrdy_q, arrdy_q, irq_out_q, verdict, verdict_ok, busy;
    logic [15:0] port_q;
    assign busy = (st_q != S_IDLE);
    // a character may only be taken while idle; host pacing keeps this safe
    wire take = rx.valid && !busy;
    wire txfree = !tx_q.valid || tx_ready;
    wire is_term = (rx.data == CH_NL) || (rx.data == CH_CR);

    ////////////////////////////////////////////////////////////////////////
    // line engine
    always_comb
    begin
        len_d = len_q;
        echo_d = echo_q;
        eot_d = eot_q;
        st_d = st_q;
        idx_d = idx_q;
        rem_d = rem_q;
        ok_d = ok_q;
        ovf_d = ovf_q;
        term_d = term_q;
        tx_d = tx_q;
        ev = 3'h0;
        if (tx_q.valid && tx_ready)
            tx_d.valid = 1'b0;
        case (st_q)
            S_IDLE:
            begin
                if (take)
                begin
                    if (rx.data == CH_ECHO_OFF)
                        echo_d = 1'b0;
                    else if (rx.data == CH_ECHO_ON)
                        echo_d = 1'b1;
                    else if (rx.data == CH_EOT_ON)
                        eot_d = 1'b1;
                    else if (rx.data == CH_EOT_OFF)
                        eot_d = 1'b0;
                    else if (rx.data == CH_BS)
                        len_d = (len_q != '0) ? len_q - 1'b1 : len_q;
                    else if (rx.data == CH_DEL || rx.data == CH_DEL2)
                        len_d = '0;
                    else if (rx.data == CH_ENQ)
                    begin
                        rem_d = 1'b1;
                        idx_d = 3'h0;
                        st_d = echo_q ? S_TEXT : S_CODE;
                    end
                    else if (is_term)
                    begin
                        term_d = rx.data;
                        // an empty line in no-echo mode gets no reply at all
                        st_d = echo_q ? S_TERM : ((len_q == '0) ? S_IDLE : S_WAIT);
                        ev[I_LINE] = !echo_q && len_q != '0;
                    end
                    else if (len_q == (AW + 1)'(DEPTH))
                    begin
                        ovf_d = 1'b1;
                        ev[I_OVF] = 1'b1;
                    end
                    // other control codes are neither stored nor counted
                    else if (rx.data >= 8'h20)
                        len_d = len_q + 1'b1;
                    if (echo_q && !is_term && rx.data != CH_ENQ && tx_d.valid == 1'b0)
                        tx_d = '{valid: 1'b1, data: rx.data};
                end
            end
            S_TERM:
                if (txfree)
                begin
                    tx_d = '{valid: 1'b1, data: term_q};
                    st_d = (len_q == '0) ? (eot_q ? S_EOT : S_IDLE) : S_WAIT;
                    ev[I_LINE] = (len_q != '0);
                end
            S_WAIT:
                if (verdict)
                begin
                    ok_d = verdict_ok;
                    rem_d = 1'b0;
                    idx_d = 3'h0;
                    len_d = '0;
                    ovf_d = 1'b0;
                    ev[I_DONE] = 1'b1;
                    if (echo_q)
                        st_d = verdict_ok ? (eot_q ? S_EOT : S_IDLE) : S_TEXT;
                    else
                        st_d = S_CODE;
                end
            S_TEXT:
                if (txfree)
                begin
                    tx_d = '{valid: 1'b1, data: text_char(rem_q, idx_q)};
                    idx_d = idx_q + 3'h1;
                    if (idx_q == 3'h5)
                        st_d = rem_q ? S_NL : S_CR;
                end
            S_CR:
                if (txfree)
                begin
                    tx_d = '{valid: 1'b1, data: CH_CR};
                    st_d = S_NL;
                end
            S_NL:
                if (txfree)
                begin
                    tx_d = '{valid: 1'b1, data: CH_NL};
                    st_d = eot_q ? S_EOT : S_IDLE;
                end
            S_CODE:
                if (txfree)
                begin
                    tx_d.valid = 1'b1;
                    tx_d.data = rem_q ? CH_GS : (ok_q ? CH_ACK : CH_BEL);
                    st_d = eot_q ? S_EOT : S_IDLE;
                end
            S_EOT:
                if (txfree)
                begin
                    tx_d = '{valid: 1'b1, data: CH_EOT};
                    st_d = S_IDLE;
                end
            default:
                st_d = S_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            len_q <= '0;
            echo_q <= 1'b1;
            eot_q <= 1'b0;
            st_q <= S_IDLE;
            idx_q <= 3'h0;
            rem_q <= 1'b0;
            ok_q <= 1'b0;
            ovf_q <= 1'b0;
            term_q <= 8'h00;
            tx_q <= '0;
        end
        else
        begin
            len_q <= len_d;
            echo_q <= echo_d;
            eot_q <= eot_d;
            st_q <= st_d;
            idx_q <= idx_d;
            rem_q <= rem_d;
            ok_q <= ok_d;
            ovf_q <= ovf_d;
            term_q <= term_d;
            tx_q <= tx_d;
        end
    end
    // line store, kept upper case so software parses case-blind
    always_ff @(posedge aclk)
    begin
        if (st_q == S_IDLE && take && !is_term && rx.data >= 8'h20 && rx.data != CH_DEL
            && rx.data != CH_DEL2 && len_q < (AW + 1)'(DEPTH))
            buf_q[len_q[AW-1:0]] <= upcase(rx.data);
    end
    ////////////////////////////////////////////////////////////////////////
    // axi4-lite slave; a write to A_RESULT bit 0 posts the verdict (1 = accept)
    wire wr_go = aw_q && w_q && !bv_q;
    assign verdict = wr_go && awa_q == A_RESULT && st_q == S_WAIT;
    assign verdict_ok = wd_q[0];
    always_comb
    begin
        aw_d = aw_q;
        w_d = w_q;
        awa_d = awa_q;
        wd_d = wd_q;
        bv_d = bv_q;
        rv_d = rv_q;
        rd_d = rd_q;
        mask_d = mask_q;
        ser_d = ser_q;
        irq_d = irq_q;
        if (s_axi_awvalid && !aw_q)
        begin
            aw_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_q)
        begin
            w_d = 1'b1;
            wd_d = s_axi_wdata;
        end
        if (wr_go)
        begin
            bv_d = 1'b1;
            aw_d = 1'b0;
            w_d = 1'b0;
            case (awa_q)
                A_MASK: mask_d = wd_q[2:0];
                A_SERCFG: ser_d = wd_q;
                A_IRQ: irq_d = irq_q & ~wd_q[2:0];
                default: ;
            endcase
        end
        irq_d = irq_d | ev; // set wins over clear
        if (bv_q && s_axi_bready)
            bv_d = 1'b0;
        if (s_axi_arvalid && !rv_q)
        begin
            rv_d = 1'b1;
            // the window end is wider than the address, so compare in ten bits
            if (s_axi_araddr >= A_BUF && 10'(s_axi_araddr) < 10'(A_BUF) + 10'(4 * DEPTH))
                rd_d = {24'h0, buf_q[AW'((s_axi_araddr - A_BUF) >> 2)]};
            else
                case (s_axi_araddr)
                    A_CTRL: rd_d = {30'h0, eot_q, echo_q};
                    A_STAT: rd_d = {27'h0, ovf_q, 1'b0, st_q};
                    A_IRQ: rd_d = {29'h0, irq_q};
                    A_MASK: rd_d = {29'h0, mask_q};
                    A_LINE: rd_d = 32'(len_q);
                    A_SERCFG: rd_d = ser_q;
                    A_PORT: rd_d = {16'h0, TCP_PORT};
                    default: rd_d = 32'h0;
                endcase
        end
        else if (rv_q && s_axi_rready)
            rv_d = 1'b0;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h0;
            bv_q <= 1'b0;
            rv_q <= 1'b0;
            rd_q <= 32'h0;
            mask_q <= 3'h0;
            ser_q <= SERCFG_RST;
            irq_q <= 3'h0;
            awrdy_q <= 1'b1;
            wrdy_q <= 1'b1;
            arrdy_q <= 1'b1;
            irq_out_q <= 1'b0;
            port_q <= 16'h0;
        end
        else
        begin
            aw_q <= aw_d;
            w_q <= w_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            bv_q <= bv_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
            mask_q <= mask_d;
            ser_q <= ser_d;
            irq_q <= irq_d;
            awrdy_q <= !aw_d;
            wrdy_q <= !w_d;
            arrdy_q <= !rv_d;
            irq_out_q <= |(irq_d & mask_d);
            port_q <= TCP_PORT;
        end
    end
    assign s_axi_awready = awrdy_q;
    assign s_axi_wready = wrdy_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = 2'b00;
    assign s_axi_arready = arrdy_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rd_q;
    assign s_axi_rresp = 2'b00;
    assign tx = tx_q;
    assign ser_cfg = ser_q;
    assign listen_port = port_q;
    assign irq = irq_out_q;
    ////////////////////////////////////////////////////////////////////////
    // checks
    echo_char_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (take && echo_q && !is_term && rx.data != CH_ENQ && !tx_q.valid)
        |=> (tx_q.valid && tx_q.data == $past(rx.data)))
        else $error("echo missing");
    echo_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (take && rx.data == CH_ECHO_OFF) |=> !echo_q)
        else $error("echo off failed");
    eot_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (take && rx.data == CH_EOT_ON) |=> eot_q)
        else $error("eot on failed");
    del_line_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (take && rx.data == CH_DEL) |=> len_q == '0)
        else $error("delete failed");
    silent_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (take && !echo_q && is_term && len_q == '0) |=> st_q == S_IDLE)
        else $error("empty line answered");
    ack_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_q == S_CODE && txfree && !rem_q && ok_q) |=> tx_q.data == CH_ACK)
        else $error("ack wrong");
    nl_eot_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_q == S_NL && txfree && eot_q) |=> st_q == S_EOT)
        else $error("eot not after nl");
    enq_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (take && rx.data == CH_ENQ && !echo_q) |=> st_q == S_CODE && rem_q)
        else $error("enq reply wrong");
endmodule

// >>> host_model.sv
// host side model: paces characters onto rx and collects what comes back on tx
// assumes the bench waits for the echo or the verdict before sending more
`timescale 1ns/1ps
module host_model
    import line_proto_pkg::*;
(
    // clock
    input wire logic aclk,
    // character streams
    output byte_t rx,
    input wire byte_t tx,
    output logic tx_ready,
    // bench control
    input wire logic slow
);
    logic [7:0] got[$];
    logic stall_q = 1'b0;

    initial rx = '{1'b0, 8'h00};
    assign tx_ready = !stall_q;

    ////////////////////////////////////////////////////////////////////////////
    // a slow host refuses every other cycle so tx must hold its byte
    always @(posedge aclk)
    begin
        stall_q <= slow && !stall_q;
        if (tx.valid && tx_ready)
            got.push_back(tx.data);
    end

    ////////////////////////////////////////////////////////////////////////////
    // one character per call; idle data shows the inverse so stale bytes are not re-read
    task automatic send(input logic [7:0] c);
        rx <= '{1'b1, c};
        @(posedge aclk);
        rx <= '{1'b0, ~c};
        repeat (3) @(posedge aclk);
    endtask
endmodule

// >>> remote_line_test.sv
// self-checking bench for the remote line handler
// assumes host_model on the character streams and an axi4-lite master here
`timescale 1ns/1ps
module remote_line_test;
    import line_proto_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic slow = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, tx_ready, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, ser_cfg;
    logic [15:0] listen_port;
    byte_t rx, tx;
    int err_total = 0;
    int cmp_count = 0;
    logic echo = 1'b1;

    always #2.5 aclk = ~aclk;

    remote_line dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rx(rx), .tx(tx), .tx_ready(tx_ready),
        .ser_cfg(ser_cfg), .listen_port(listen_port), .irq(irq));

    host_model host_u (.aclk(aclk), .rx(rx), .tx(tx), .tx_ready(tx_ready), .slow(slow));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // address and data go out together; each is dropped on its own ready
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_p, w_p;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        aw_p = 1'b1;
        w_p = 1'b1;
        while (aw_p || w_p)
        begin
            @(posedge aclk);
            if (aw_p && awready === 1'b1)
            begin
                aw_p = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_p && wready === 1'b1)
            begin
                w_p = 1'b0;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        chk(bresp, 2'b00);
        bready <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        chk(rdata, exp);
        chk(rresp, 2'b00);
        rready <= 1'b0;
    endtask

    task automatic expect_str(input string s);
        for (int i = 0; i < s.len(); i++)
        begin
            while (host_u.got.size() == 0) @(posedge aclk);
            chk({24'h0, host_u.got.pop_front()}, {24'h0, s[i]});
        end
    endtask

    // nothing more may arrive on tx
    task automatic quiet;
        repeat (30) @(posedge aclk);
        chk(host_u.got.size(), 0);
    endtask

    // the host waits for each echo before the next character
    task automatic say(input string s);
        for (int i = 0; i < s.len(); i++)
        begin
            host_u.send(s[i]);
            if (echo)
                expect_str(s.substr(i, i));
        end
    endtask

    task automatic run_line(input string s, input string term, input logic [31:0] ok,
        input string resp, input logic [31:0] len, input logic [7:0] first);
        say({s, term});
        while (irq !== 1'b1) @(posedge aclk);
        rdc(A_LINE, len);
        rdc(A_BUF, {24'h0, first});
        wr(A_RESULT, ok);
        expect_str(resp);
        quiet;
        wr(A_IRQ, 32'h0000_0007);
        chk(irq, 1'b0);
    endtask

    task automatic enq(input string resp);
        host_u.send(CH_ENQ);
        expect_str(resp);
        quiet;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdc(A_CTRL, 32'h0000_0001);
        rdc(A_LINE, 32'h0);
        rdc(A_STAT, 32'h0);
        rdc(A_PORT, 32'h0000_1771);
        chk(listen_port, 16'h1771);
        rdc(A_SERCFG, SERCFG_RST);
        wr(A_SERCFG, 32'h0000_4B00);
        rdc(A_SERCFG, 32'h0000_4B00);
        chk(ser_cfg, 32'h0000_4B00);
        rdc(8'h30, 32'h0);
        $display("test reset done");
        wr(A_MASK, 32'h0000_0001);
        slow <= 1'b1;
        run_line("a?", "\r", 0, "ERROR:\r\n", 2, "A");
        slow <= 1'b0;
        run_line("xy\010\177bz\303k\010m", "\n", 1, "", 1, "M");
        enq("REMOTE\n");
        $display("test echo done");
        say("\016");
        rdc(A_CTRL, 32'h0000_0003);
        enq("REMOTE\n\004");
        run_line("q", "\r", 0, "ERROR:\r\n\004", 1, "Q");
        say("\022");
        echo = 1'b0;
        rdc(A_CTRL, 32'h0000_0002);
        run_line("ok", "\r", 1, "\006\004", 2, "O");
        run_line("n", "\n", 0, "\007\004", 1, "N");
        say("\r");
        quiet;
        enq("\035\004");
        say("\017");
        rdc(A_CTRL, 32'h0);
        enq("\035");
        $display("test no-echo done");
        wr(A_MASK, 32'h0);
        say("z\r");
        repeat (20) @(posedge aclk);
        chk(irq, 1'b0);
        rdc(A_LINE, 32'h0000_0001);
        wr(A_RESULT, 32'h0000_0001);
        expect_str("\006");
        quiet;
        wr(A_IRQ, 32'h0000_0007);
        say("\024");
        echo = 1'b1;
        rdc(A_CTRL, 32'h0000_0001);
        $display("test mask and modes done");
        test_done;
    end

    // the tests need well under a thousand cycles; this leaves ample margin
    initial
    begin
        repeat (40000) @(posedge aclk);
        err_total++;
        test_done;
    end
endmodule
